// >>> rdc_consts.vh
// Constants for the ratiometric reference converter control block
`ifndef RDC_CONSTS_VH
`define RDC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RDC_OFF_CTRL 4'h0
`define RDC_OFF_LEVEL 4'h4
`define RDC_OFF_STATUS 4'h8

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define RDC_BIT_EN 7
`define RDC_BIT_LPS 6
`define RDC_BIT_OE 5
`define RDC_PSS_HI 3
`define RDC_PSS_LO 2
`define RDC_BIT_NSS 0
// Implemented bits of the control register
`define RDC_CTRL_MASK 8'hed

// ----------------------------------------------------------------
// Level code register
// ----------------------------------------------------------------
`define RDC_LEVEL_W 5
`define RDC_LEVEL_MAX 5'h1f
`define RDC_LEVEL_SHIFT 5

// ----------------------------------------------------------------
// Positive source select codes
// ----------------------------------------------------------------
`define RDC_PSS_SUPPLY 2'h0
`define RDC_PSS_EXT 2'h1
`define RDC_PSS_FIXED 2'h2
`define RDC_PSS_RSVD 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RDC_CTRL_RST 8'h00
`define RDC_LEVEL_RST 5'h00

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RDC_RESP_OKAY 2'h0
`define RDC_RESP_SLVERR 2'h2

`endif

// >>> rdc_ctrl.v
// Ratiometric reference converter control logic with AXI4-Lite slave
`timescale 1ns/1ps
`include "rdc_consts.vh"

module rdc_ctrl (
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire awvalid,
  output reg awready,
  input wire [3:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data
  input wire wvalid,
  output reg wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output reg arready,
  input wire [3:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Digitised source levels
  input wire [7:0] supply_level,
  input wire [7:0] ext_pos_level,
  input wire [7:0] fixed_ref_level,
  input wire [7:0] ext_neg_level,
  // Port logic facing the reference output pin
  input wire port_out,
  input wire port_oe,
  input wire pin_in,
  // Converter controls
  output reg converter_enable_q,
  output reg pos_connect_q,
  output reg neg_connect_q,
  output reg [1:0] positive_source_select_q,
  output reg negative_source_select_q,
  output reg [4:0] level_code_q,
  output reg [7:0] level_out_q,
  // Reference output pin
  output reg pin_route_q,
  output reg buffer_override_q,
  output reg input_override_q,
  output reg pin_out_q,
  output reg pin_oe_q,
  output reg pin_read_q
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [7:0] ctrl_q; // Control register, implemented bits only
  reg [7:0] ctrl_d;
  reg [4:0] level_d;

  // Field views of the control register
  wire en_bit = ctrl_q[`RDC_BIT_EN];
  wire lps_bit = ctrl_q[`RDC_BIT_LPS];
  wire oe_bit = ctrl_q[`RDC_BIT_OE];
  wire [1:0] pss_bits = ctrl_q[`RDC_PSS_HI:`RDC_PSS_LO];
  wire nss_bit = ctrl_q[`RDC_BIT_NSS];

  // ----------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------
  reg aw_got_q; // Address held, waiting for data
  reg w_got_q; // Data held, waiting for address
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg aw_got_d;
  reg w_got_d;
  reg bvalid_d;
  reg [1:0] bresp_d;
  reg do_write; // Both halves present this cycle

  // Handshakes on the write side
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;

  // Write sequencing; address and data may come in either order
  always @* begin
    aw_got_d = aw_got_q | aw_hs;
    w_got_d = w_got_q | w_hs;
    bvalid_d = bvalid;
    bresp_d = bresp;
    do_write = 1'b0;
    // Retire the response first
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    // Commit once both halves are in and no response is pending
    if (aw_got_q && w_got_q && !bvalid) begin
      do_write = 1'b1;
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      if (aw_addr_q == `RDC_OFF_CTRL || aw_addr_q == `RDC_OFF_LEVEL ||
          aw_addr_q == `RDC_OFF_STATUS) begin
        bresp_d = `RDC_RESP_OKAY;
      end else begin
        // Unmapped address
        bresp_d = `RDC_RESP_SLVERR;
      end
    end
  end

  // Write channel registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RDC_RESP_OKAY;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      // Capture payloads on their own handshakes
      if (aw_hs) begin
        aw_addr_q <= {awaddr[3:2], 2'h0};
      end
      if (w_hs) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      // Ready only while the slot is free, one write in flight
      awready <= ~aw_got_d & ~bvalid_d & ~(aw_got_q & w_got_q);
      wready <= ~w_got_d & ~bvalid_d & ~(aw_got_q & w_got_q);
      bvalid <= bvalid_d;
      bresp <= bresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  // Only lane 0 carries register bits; upper lanes are ignored
  always @* begin
    ctrl_d = ctrl_q;
    level_d = level_code_q;
    if (do_write && w_strb_q[0]) begin
      if (aw_addr_q == `RDC_OFF_CTRL) begin
        ctrl_d = w_data_q[7:0] & `RDC_CTRL_MASK;
      end
      if (aw_addr_q == `RDC_OFF_LEVEL) begin
        level_d = w_data_q[4:0];
      end
    end
  end

  // Only a bus write or reset changes these; sleep and wake do not
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `RDC_CTRL_RST;
      level_code_q <= `RDC_LEVEL_RST;
    end else begin
      ctrl_q <= ctrl_d;
      level_code_q <= level_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  reg pin_s1_q; // First stage, read only by the second
  reg pin_s2_q;
  reg pin_s3_q;
  reg pin_level_q; // Filtered pin level

  // A change counts only once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_level_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_level_q <= pin_s3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ladder source selection and level model
  // ----------------------------------------------------------------
  reg [7:0] pos_src; // Selected positive source
  reg [7:0] neg_src; // Selected negative source
  reg [7:0] level_d8;
  reg [12:0] prod; // Difference times code, before the divide
  reg [7:0] diff;

  // Positive source mux; the reserved code yields a zero source
  always @* begin
    case (pss_bits)
      `RDC_PSS_SUPPLY: pos_src = supply_level;
      `RDC_PSS_EXT: pos_src = ext_pos_level;
      `RDC_PSS_FIXED: pos_src = fixed_ref_level;
      default: pos_src = 8'h00;
    endcase
  end

  // Negative source mux: ground rail or external reference
  always @* begin
    if (nss_bit) begin
      neg_src = ext_neg_level;
    end else begin
      neg_src = 8'h00;
    end
  end

  // Ladder tap; sign handled by magnitude so no bits are lost
  always @* begin
    diff = 8'h00;
    prod = 13'h0000;
    level_d8 = neg_src;
    if (!en_bit) begin
      // Idle ladder follows whichever end stays connected
      if (lps_bit) begin
        level_d8 = pos_src;
      end else begin
        level_d8 = neg_src;
      end
    end else if (pos_src >= neg_src) begin
      diff = pos_src - neg_src;
      prod = diff * level_code_q;
      level_d8 = neg_src + prod[12:5];
    end else begin
      // Inverted references still scale ratiometrically
      diff = neg_src - pos_src;
      prod = diff * level_code_q;
      level_d8 = neg_src - prod[12:5];
    end
  end

  // ----------------------------------------------------------------
  // Converter and pin outputs
  // ----------------------------------------------------------------
  // All outputs registered so the analog switches see clean levels
  always @(posedge aclk) begin
    if (!aresetn) begin
      converter_enable_q <= 1'b0;
      pos_connect_q <= 1'b0;
      neg_connect_q <= 1'b0;
      positive_source_select_q <= `RDC_PSS_SUPPLY;
      negative_source_select_q <= 1'b0;
      level_out_q <= 8'h00;
      pin_route_q <= 1'b0;
      buffer_override_q <= 1'b0;
      input_override_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      pin_read_q <= 1'b0;
    end else begin
      converter_enable_q <= en_bit;
      // Enabled ladder keeps both ends; idle ladder drops one
      pos_connect_q <= en_bit | lps_bit;
      neg_connect_q <= en_bit | ~lps_bit;
      positive_source_select_q <= pss_bits;
      negative_source_select_q <= nss_bit;
      level_out_q <= level_d8;
      pin_route_q <= oe_bit;
      buffer_override_q <= oe_bit;
      input_override_q <= oe_bit;
      // Digital driver is cut off while the reference owns the pin
      if (oe_bit) begin
        pin_out_q <= 1'b0;
        pin_oe_q <= 1'b0;
        pin_read_q <= 1'b0;
      end else begin
        pin_out_q <= port_out;
        pin_oe_q <= port_oe;
        pin_read_q <= pin_level_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;

  // Read decode; unimplemented bits come back as zero
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `RDC_RESP_OKAY;
    case ({araddr[3:2], 2'h0})
      `RDC_OFF_CTRL: rdata_d = {24'h000000, ctrl_q};
      `RDC_OFF_LEVEL: rdata_d = {27'h0000000, level_code_q};
      `RDC_OFF_STATUS: rdata_d = {23'h000000, pin_read_q, level_out_q};
      default: rresp_d = `RDC_RESP_SLVERR;
    endcase
  end

  // One read at a time; address is refused while data waits
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RDC_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdata_d;
        rresp <= rresp_d;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

endmodule

// >>> rdc_ctrl_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "rdc_consts.vh"
module rdc_ctrl_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, port_out = 0, port_oe = 0, pin_in = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic [2:0] awprot = 0, arprot = 0;
  logic [31:0] wdata = 0, rdata, rd_q, r = 32'h000122c6;
  logic [1:0] bresp, rresp, rs, positive_source_select_q;
  logic [7:0] supply_level = 0, ext_pos_level = 0, fixed_ref_level = 0, ext_neg_level = 0, c;
  logic converter_enable_q, pos_connect_q, neg_connect_q, negative_source_select_q;
  logic pin_route_q, buffer_override_q, input_override_q, pin_out_q, pin_oe_q, pin_read_q;
  logic [4:0] level_code_q, k;
  logic [7:0] level_out_q;
  integer err_total = 0, total_checks = 0, i, t;
  rdc_ctrl uut (.*);
  // Free-running clock, 4 ns
  always #2 aclk = ~aclk;
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tick(input integer q);
    repeat (q) @(posedge aclk);
  endtask
  task chk(input string s, input logic [31:0] v, input logic [31:0] x);
    total_checks++;
    if (v !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", s, x, v);
    end
  endtask
  // Bounded wait ran out: count it and stop
  task hang;
    err_total++;
    complete_run;
  endtask
  // Write: address and data offered together, bready held until response
  task wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    rs = bresp; bready <= 0;
    if (t == 40) hang;
  endtask
  // Read: rready held from the start, data taken at the rvalid edge
  task rd(input logic [3:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd_q = rdata; rs = rresp; rready <= 0;
    if (t == 40) hang;
  endtask
  function automatic logic [31:0] nx(input logic [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Reference level from control, code and source levels
  function integer mdl;
    integer p, n;
    p = c[3:2] == 0 ? supply_level : c[3:2] == 1 ? ext_pos_level : c[3:2] == 2 ? fixed_ref_level : 0;
    n = c[0] ? ext_neg_level : 0;
    if (c[7]) mdl = p >= n ? n + (p - n) * k / 32 : n - (n - p) * k / 32;
    else mdl = c[6] ? p : n;
  endfunction
  initial begin
    tick(8);
    aresetn <= 1;
    tick(2);
    rd(`RDC_OFF_CTRL); chk("ctrl", rd_q, 0);
    rd(`RDC_OFF_LEVEL); chk("code", rd_q, 0);
    $display("test reset values done");
    // Random settings, every legal positive select code, both clamps forced
    for (i = 0; i < 16; i++) begin
      r = nx(r); c = {r[7:4], i[1:0], r[1:0]}; k = r[12:8];
      c[3:2] = 2'(i % 3);
      if (i == 4) begin c[7:6] = 2'b01; k = 5'h1f; end
      if (i == 5) begin c[7:6] = 2'b00; k = 5'h00; end
      supply_level <= r[31:24]; ext_pos_level <= r[23:16];
      fixed_ref_level <= r[20:13]; ext_neg_level <= r[17:10];
      wr(`RDC_OFF_CTRL, {r[31:8], c});
      wr(`RDC_OFF_LEVEL, {r[31:5], k});
      tick(3);
      rd(`RDC_OFF_STATUS); chk("status", rd_q, mdl());
      rd(`RDC_OFF_CTRL); chk("ctrl", rd_q, c & `RDC_CTRL_MASK);
      rd(`RDC_OFF_LEVEL); chk("code", rd_q, k);
      chk("enable", converter_enable_q, c[7]);
      chk("pos_connect", pos_connect_q, c[7] | c[6]);
      chk("neg_connect", neg_connect_q, c[7] | !c[6]);
      chk("pin_route", pin_route_q, c[5]);
      chk("level_code", level_code_q, k);
      chk("sources", {positive_source_select_q, negative_source_select_q}, {c[3:2], c[0]});
    end
    $display("test levels done");
    port_out <= 1; port_oe <= 1; pin_in <= 1;
    wr(`RDC_OFF_CTRL, 32'h00000020);
    tick(8);
    chk("pin_oe", pin_oe_q, 0);
    chk("input_override", input_override_q, 1);
    chk("buffer_override", buffer_override_q, 1);
    chk("pin_out", pin_out_q, 0);
    chk("pin_route", pin_route_q, 1);
    rd(`RDC_OFF_STATUS); chk("pin_read", rd_q[8], 0);
    wr(`RDC_OFF_CTRL, 32'h00000000);
    tick(8);
    chk("pin_oe", pin_oe_q, 1);
    chk("pin_read", pin_read_q, 1);
    chk("pin_out", pin_out_q, 1);
    chk("pin_route", pin_route_q, 0);
    chk("buffer_override", buffer_override_q, 0);
    $display("test pin done");
    rd(4'hc); chk("resp", rs, `RDC_RESP_SLVERR);
    chk("data", rd_q, 0);
    wr(4'hc, 32'h000000ff); chk("wresp", rs, `RDC_RESP_SLVERR);
    // Lane 0 disabled: the level code must keep its old value
    wstrb <= 4'he;
    wr(`RDC_OFF_LEVEL, 32'h0000001f);
    wstrb <= 4'hf;
    rd(`RDC_OFF_LEVEL); chk("code", rd_q, k);
    rd(`RDC_OFF_CTRL); chk("ctrl", rd_q, 0);
    $display("test unmapped done");
    wr(`RDC_OFF_CTRL, 32'h000000a5); wr(`RDC_OFF_LEVEL, 32'h00000011);
    aresetn <= 0;
    tick(2);
    aresetn <= 1;
    tick(2);
    rd(`RDC_OFF_CTRL); chk("ctrl", rd_q, 0);
    rd(`RDC_OFF_LEVEL); chk("code", rd_q, 0);
    chk("enable", converter_enable_q, 0);
    chk("pin_route", pin_route_q, 0);
    chk("level_code", level_code_q, 0);
    $display("test second reset done");
    complete_run;
  end
endmodule

// >>> rdc_ctrl_checker.sv
// Concurrent checks on the converter control outputs
`timescale 1ns/1ps
module rdc_ctrl_checker (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] supply_level,
  input logic [7:0] ext_pos_level,
  input logic [7:0] fixed_ref_level,
  input logic [7:0] ext_neg_level,
  input logic port_out,
  input logic port_oe,
  input logic converter_enable_q,
  input logic pos_connect_q,
  input logic neg_connect_q,
  input logic [1:0] positive_source_select_q,
  input logic negative_source_select_q,
  input logic [4:0] level_code_q,
  input logic [7:0] level_out_q,
  input logic pin_route_q,
  input logic buffer_override_q,
  input logic input_override_q,
  input logic pin_out_q,
  input logic pin_oe_q,
  input logic pin_read_q
);
  // ----------------------------------------
  // Helper copies, aligned with the output flops
  // ----------------------------------------
  logic [7:0] sq, eq, fq, nq, p, n, e;
  logic [4:0] kq;
  logic [12:0] m;
  logic ok_q;
  // Inputs one edge old, as the output flop saw them
  always @(posedge aclk) begin
    sq <= supply_level;
    eq <= ext_pos_level;
    fq <= fixed_ref_level;
    nq <= ext_neg_level;
    kq <= level_code_q;
    ok_q <= aresetn;
  end
  // Reserved select gives a zero source
  assign p = (positive_source_select_q == 2'h0) ? sq : (positive_source_select_q == 2'h1) ? eq :
    (positive_source_select_q == 2'h2) ? fq : 8'h00;
  assign n = negative_source_select_q ? nq : 8'h00;
  assign m = (p >= n ? p - n : n - p) * kq;
  assign e = (p >= n) ? n + m[12:5] : n - m[12:5];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_enable_both_ends: assert property (ok_q && converter_enable_q |-> pos_connect_q && neg_connect_q)
    else $error("enabled ladder lost an end");
  a_low_power_drop: assert property (ok_q && !converter_enable_q |-> pos_connect_q != neg_connect_q)
    else $error("disabled ladder keeps wrong ends");
  a_level_calc: assert property (ok_q && converter_enable_q |-> level_out_q == e)
    else $error("enabled level wrong");
  a_clamp_pos: assert property (ok_q && !converter_enable_q && pos_connect_q |-> level_out_q == p)
    else $error("positive clamp wrong");
  a_clamp_neg: assert property (ok_q && !converter_enable_q && neg_connect_q |-> level_out_q == n)
    else $error("negative clamp wrong");
  a_pin_override: assert property (buffer_override_q == pin_route_q && input_override_q == pin_route_q)
    else $error("override does not follow routing");
  a_pin_quiet: assert property (pin_route_q |-> !pin_oe_q && !pin_out_q && !pin_read_q)
    else $error("routed pin still digital");
  a_pin_pass: assert property (ok_q && !pin_route_q |-> pin_oe_q == $past(port_oe) &&
    pin_out_q == $past(port_out))
    else $error("unrouted pin not passed through");
  c_enabled: cover property (converter_enable_q);
  c_routed: cover property (pin_route_q);
  c_clamp: cover property (!converter_enable_q && pos_connect_q);
endmodule
bind rdc_ctrl rdc_ctrl_checker chk_i (.*);
